// ### piu_unit.sv
// eight-level priority interrupt unit with daisy-chain group enable
`timescale 1ns/1ps
`include "piu_defs.svh"

module piu_unit
    import piu_pkg::*;
#(
    parameter int LEVELS = `PIU_LEVELS, // requests per unit
    parameter int LVL_W = `PIU_LVL_W    // width of a level code
) (
    input wire logic clock,                       // 25 MHz clock
    input wire logic resetn,                      // async reset, active low
    input wire logic clock_enable,                // low freezes all state
    input wire logic [LEVELS-1:0] request_n,      // requests, active low
    input wire logic strobe_enable,               // interrupt strobe, high
    input wire logic status_load_n,               // load status, active low
    input wire logic [LVL_W-1:0] current_level_n, // new level, active low
    input wire logic status_group_select_n,       // level is ours, active low
    input wire logic group_inhibit_in,            // high lets this group run
    input wire logic level_read_en_n,             // read level pins, low
    input wire logic interrupt_acknowledge_n_i,   // wired acknowledge line
    output logic interrupt_acknowledge_n_o,       // acknowledge drive level
    output logic interrupt_acknowledge_n_oe,      // acknowledge pulled low
    output logic [LVL_W-1:0] request_level_n_o,   // level code, active low
    output logic request_level_n_oe,              // level pins driven
    output logic group_inhibit_out                // high enables next group
);

    // ****************************************************************
    // parameter check
    // ****************************************************************
    generate
        if (LEVELS != `PIU_LEVELS || LVL_W != `PIU_LVL_W) begin : g_bad_size
            $error("piu_unit: state layout is fixed at eight levels");
        end
    endgenerate

    localparam piu_state_t ST_RST = '{
        req: `PIU_REQ_RST,
        lvl: `PIU_LVL_RST,
        grp: `PIU_GRP_RST,
        dis: `PIU_DIS_RST,
        ack: `PIU_ACK_RST,
        ia_n: `PIU_IA_N_RST,
        a_n: `PIU_A_N_RST,
        a_oe: `PIU_A_OE_RST,
        gio: `PIU_GIO_RST
    };

    // ****************************************************************
    // state and helpers
    // ****************************************************************
    piu_state_t st_reg;
    piu_state_t st_next;
    logic enc_valid;
    logic [LVL_W-1:0] enc_code;
    logic line_ack;
    logic dis_eff;
    logic req_above;

    // a request beats the status if the status sits in another group
    // (a higher group would already have closed group_inhibit_in)
    function automatic logic above_status(
        input logic valid,
        input logic [LVL_W-1:0] code,
        input logic [LVL_W-1:0] lvl,
        input logic grp
    );
        above_status = valid && (!grp || (code > lvl));
    endfunction : above_status

    piu_prio_enc #(
        .LEVELS(LEVELS),
        .CODE_W(LVL_W)
    ) u_enc (
        .req(st_reg.req),
        .valid(enc_valid),
        .code(enc_code)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_next = st_reg;
        // the wired line counts too: an acknowledge from any unit on the
        // line freezes this one, as the shared pin would
        line_ack = st_reg.ack || !interrupt_acknowledge_n_i;
        dis_eff = st_reg.dis || line_ack;
        req_above = above_status(enc_valid, enc_code, st_reg.lvl, st_reg.grp);

        // request latch, transparent until an acknowledge freezes it
        if (!dis_eff) begin
            st_next.req = ~request_n;
        end

        // current status latch
        if (!status_load_n) begin
            st_next.lvl = ~current_level_n;
            st_next.grp = !status_group_select_n;
        end

        // disable flop: set wins over the load clear
        if (line_ack) begin
            st_next.dis = 1'b1;
        end else if (!status_load_n) begin
            st_next.dis = 1'b0;
        end

        // interrupt flop; dis_eff includes its own state, so one cycle only
        st_next.ack = req_above && strobe_enable && group_inhibit_in && !dis_eff;
        st_next.ia_n = !st_next.ack;

        // level pins: only the unit above status may drive them
        st_next.a_n = ~enc_code;
        st_next.a_oe = req_above && group_inhibit_in && !level_read_en_n;

        // daisy chain to the next lower group
        st_next.gio = group_inhibit_in && !st_reg.grp && !enc_valid;
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_reg <= ST_RST;
        end else if (clock_enable) begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // open collector: drive level is low whenever the enable is up
    assign interrupt_acknowledge_n_o = st_reg.ia_n;
    assign interrupt_acknowledge_n_oe = st_reg.ack;
    assign request_level_n_o = st_reg.a_n;
    assign request_level_n_oe = st_reg.a_oe;
    assign group_inhibit_out = st_reg.gio;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_ack_one_cycle:
    assert property (@(posedge clock) disable iff (!resetn)
        (st_reg.ack && clock_enable) |=> !st_reg.ack)
    else $error("acknowledge held longer than one cycle");

    a_ack_cause:
    assert property (@(posedge clock) disable iff (!resetn)
        $rose(st_reg.ack) |->
            $past(clock_enable && strobe_enable && group_inhibit_in
                  && enc_valid && !st_reg.dis))
    else $error("acknowledge set without its conditions");

    a_ack_above:
    assert property (@(posedge clock) disable iff (!resetn)
        ($rose(st_reg.ack) && $past(st_reg.grp)) |->
            ($past(enc_code) > $past(st_reg.lvl)))
    else $error("acknowledge at or below current level");

    a_ack_sets_dis:
    assert property (@(posedge clock) disable iff (!resetn)
        (st_reg.ack && clock_enable) |=> st_reg.dis)
    else $error("acknowledge did not set disable");

    a_dis_blocks_ack:
    assert property (@(posedge clock) disable iff (!resetn)
        st_reg.dis |=> !st_reg.ack)
    else $error("acknowledge while disabled");

    a_ack_beats_clear:
    assert property (@(posedge clock) disable iff (!resetn)
        (st_reg.ack && clock_enable && !status_load_n) |=> st_reg.dis)
    else $error("status load cleared disable during acknowledge");

    a_load_clears_dis:
    assert property (@(posedge clock) disable iff (!resetn)
        (clock_enable && !status_load_n && !st_reg.ack && interrupt_acknowledge_n_i)
            |=> !st_reg.dis)
    else $error("status load left disable set");

    a_req_frozen:
    assert property (@(posedge clock) disable iff (!resetn)
        (st_reg.dis && clock_enable) |=> $stable(st_reg.req))
    else $error("request latch moved while frozen");

    a_status_load:
    assert property (@(posedge clock) disable iff (!resetn)
        (clock_enable && !status_load_n) |=>
            (st_reg.lvl == ~$past(current_level_n)
             && st_reg.grp == !$past(status_group_select_n)))
    else $error("status latch not loaded");

    a_chain_inhibit:
    assert property (@(posedge clock) disable iff (!resetn)
        (clock_enable && !group_inhibit_in) |=> (!group_inhibit_out && !st_reg.ack))
    else $error("inhibit did not pass down the chain");

    a_chain_local_req:
    assert property (@(posedge clock) disable iff (!resetn)
        (clock_enable && (enc_valid || st_reg.grp)) |=> !group_inhibit_out)
    else $error("next group enabled despite local claim");

    a_level_release:
    assert property (@(posedge clock) disable iff (!resetn)
        (clock_enable && level_read_en_n) |=> !request_level_n_oe)
    else $error("level pins driven without read enable");

    a_level_code:
    assert property (@(posedge clock) disable iff (!resetn)
        request_level_n_oe |-> (request_level_n_o == ~$past(enc_code)
                                || !$past(clock_enable)))
    else $error("level pins do not show highest request");

    a_ack_pin_low:
    assert property (@(posedge clock) disable iff (!resetn)
        interrupt_acknowledge_n_oe |-> !interrupt_acknowledge_n_o)
    else $error("acknowledge enabled with a high drive level");

    a_ack_needs_strobe:
    assert property (@(posedge clock) disable iff (!resetn)
        (clock_enable && !strobe_enable) |=> !st_reg.ack)
    else $error("acknowledge without strobe");

    a_ack_needs_req:
    assert property (@(posedge clock) disable iff (!resetn)
        (clock_enable && !enc_valid) |=> !st_reg.ack)
    else $error("acknowledge without a latched request");

    a_ack_blocks_level:
    assert property (@(posedge clock) disable iff (!resetn)
        (clock_enable && st_reg.grp && enc_code <= st_reg.lvl) |=> !st_reg.ack)
    else $error("acknowledge at a blocked level");

    a_ack_fires_above:
    assert property (@(posedge clock) disable iff (!resetn)
        (clock_enable && enc_valid && st_reg.grp && enc_code > st_reg.lvl
         && strobe_enable && group_inhibit_in && !dis_eff) |=> st_reg.ack)
    else $error("request above status not acknowledged");

    a_ack_fires_foreign:
    assert property (@(posedge clock) disable iff (!resetn)
        (clock_enable && enc_valid && !st_reg.grp && strobe_enable
         && group_inhibit_in && !dis_eff) |=> st_reg.ack)
    else $error("request under foreign status not acknowledged");

    a_req_tracks_pins:
    assert property (@(posedge clock) disable iff (!resetn)
        (clock_enable && !dis_eff) |=> (st_reg.req == ~$past(request_n)))
    else $error("open request latch did not follow its inputs");

    a_line_sets_dis:
    assert property (@(posedge clock) disable iff (!resetn)
        (clock_enable && !interrupt_acknowledge_n_i) |=> st_reg.dis)
    else $error("wired acknowledge did not set disable");

    a_status_holds:
    assert property (@(posedge clock) disable iff (!resetn)
        (clock_enable && status_load_n) |=> ($stable(st_reg.lvl) && $stable(st_reg.grp)))
    else $error("status latch moved without a load");

    a_dis_holds:
    assert property (@(posedge clock) disable iff (!resetn)
        (clock_enable && st_reg.dis && status_load_n) |=> st_reg.dis)
    else $error("disable cleared without a status load");

    a_chain_open:
    assert property (@(posedge clock) disable iff (!resetn)
        (clock_enable && group_inhibit_in && !st_reg.grp && !enc_valid)
            |=> group_inhibit_out)
    else $error("next group not enabled");

    a_level_drive:
    assert property (@(posedge clock) disable iff (!resetn)
        (clock_enable && !level_read_en_n && group_inhibit_in && req_above)
            |=> request_level_n_oe)
    else $error("level pins not driven on read");

    a_level_only_above:
    assert property (@(posedge clock) disable iff (!resetn)
        (clock_enable && !req_above) |=> !request_level_n_oe)
    else $error("level pins driven without a request above status");

    a_enable_freezes:
    assert property (@(posedge clock) disable iff (!resetn)
        !clock_enable |=> $stable(st_reg))
    else $error("state moved while clock enable low");

endmodule : piu_unit

// ### piu_defs.svh
// constants of the priority interrupt unit: sizes and reset values
`ifndef PIU_DEFS_SVH
`define PIU_DEFS_SVH

// ****************************************************************
// sizes
// ****************************************************************
`define PIU_LEVELS 8
`define PIU_LVL_W 3

// ****************************************************************
// reset values
// ****************************************************************
`define PIU_REQ_RST 8'h00
`define PIU_LVL_RST 3'h0
`define PIU_GRP_RST 1'h0
`define PIU_DIS_RST 1'h0
`define PIU_ACK_RST 1'h0
`define PIU_IA_N_RST 1'h1
`define PIU_A_N_RST 3'h7
`define PIU_A_OE_RST 1'h0
`define PIU_GIO_RST 1'h0

`endif

// ### piu_pkg.sv
// types of the priority interrupt unit
`include "piu_defs.svh"

package piu_pkg;

    // whole state of the unit, registered in one place
    typedef struct packed {
        logic [`PIU_LEVELS-1:0] req; // request latch, active high
        logic [`PIU_LVL_W-1:0] lvl;  // current status level
        logic grp;                   // current status is in this group
        logic dis;                   // interrupt disable flop
        logic ack;                   // interrupt flop, active high
        logic ia_n;                  // acknowledge pin level
        logic [`PIU_LVL_W-1:0] a_n;  // request level pins, active low
        logic a_oe;                  // request level pins driven
        logic gio;                   // enable for next group
    } piu_state_t;

endpackage : piu_pkg

// ### piu_prio_enc.sv
// priority encoder: binary code of the highest active request
`timescale 1ns/1ps
`include "piu_defs.svh"

module piu_prio_enc #(
    parameter int LEVELS = `PIU_LEVELS, // request lines
    parameter int CODE_W = `PIU_LVL_W   // code width
) (
    input wire logic [LEVELS-1:0] req,   // latched requests, active high
    output logic valid,                  // some request active
    output logic [CODE_W-1:0] code       // highest active line
);

    // ****************************************************************
    // parameter check
    // ****************************************************************
    generate
        if (LEVELS != (1 << CODE_W)) begin : g_bad_size
            $error("piu_prio_enc: LEVELS must equal 2**CODE_W");
        end
    endgenerate

    // ****************************************************************
    // encoder
    // ****************************************************************
    // line 0 is lowest, so a later hit overrides an earlier one
    always_comb begin
        valid = 1'b0;
        code = '0;
        for (int i = 0; i < LEVELS; i++) begin
            if (req[i]) begin
                valid = 1'b1;
                code = CODE_W'(i);
            end
        end
    end

endmodule : piu_prio_enc

// ### piu_cpu_model.sv
// processor model that services every acknowledge of the unit except one rising in the first cycle of a return
`timescale 1ns/1ps

module piu_cpu_model (
    input wire logic clock, // unit clock
    input wire logic strobe_on, // allow interrupts
    input wire logic [1:0] slow, // wait before service
    input wire logic ret, // leave newest routine
    input wire logic ack_n, // wired acknowledge
    input wire logic [2:0] level_n, // wired level bus
    output logic strobe_enable, // interrupt strobe
    output logic level_read_en_n, // read level bus
    output logic status_load_n, // load status
    output logic [2:0] current_level_n, // status level
    output logic status_group_select_n, // our group
    output logic served, // one cycle per service
    output logic [2:0] served_level // level serviced
);
    logic [3:0] stk[$];

    assign strobe_enable = strobe_on;
    initial begin
        level_read_en_n = 1'b1;
        status_load_n = 1'b1;
        {status_group_select_n, current_level_n} = 4'hf;
        served = 1'b0;
        served_level = 3'h0;
    end
    // falling edges only, so the unit always samples settled inputs
    always begin
        @(negedge clock);
        if (ack_n === 1'b0) begin
            repeat (slow) @(negedge clock);
            level_read_en_n = 1'b0;
            @(negedge clock);
            stk.push_back({status_group_select_n, current_level_n});
            served_level = ~level_n;
            {status_group_select_n, current_level_n} = {1'b0, level_n};
            status_load_n = 1'b0;
            level_read_en_n = 1'b1;
            served = 1'b1;
            @(negedge clock);
            status_load_n = 1'b1;
            served = 1'b0;
        end else if (ret === 1'b1 && stk.size() > 0) begin
            {status_group_select_n, current_level_n} = stk.pop_back();
            status_load_n = 1'b0;
            @(negedge clock);
            status_load_n = 1'b1;
        end
    end
endmodule : piu_cpu_model

// ### test_priority_interrupt_unit.sv
// self-checking bench of the unit against a processor model
`timescale 1ns/1ps

module test_priority_interrupt_unit;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] request_n = 8'hff;
    logic group_inhibit_in = 1'b0;
    logic strobe_on = 1'b1;
    logic [1:0] slow = 2'h0;
    logic ret = 1'b0;
    logic clock_enable = 1'b1;
    logic strobe_enable, level_read_en_n, status_load_n, status_group_select_n, served;
    logic [2:0] current_level_n, level_o, served_level, h;
    logic ack_o, ack_oe, level_oe, group_inhibit_out;
    logic [7:0] bits;
    logic [2:0] exp_q[$];
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int acks = 0;
    int c0;
    // open collector lines float high through pull-ups
    wire ack_n = ack_oe ? ack_o : 1'b1;
    wire [2:0] level_n = level_oe ? level_o : 3'h7;

    always #20 clock = ~clock;

    piu_unit piu_unit_inst (.clock(clock), .resetn(resetn), .clock_enable(clock_enable),
        .request_n(request_n), .strobe_enable(strobe_enable), .status_load_n(status_load_n),
        .current_level_n(current_level_n), .status_group_select_n(status_group_select_n),
        .group_inhibit_in(group_inhibit_in), .level_read_en_n(level_read_en_n),
        .interrupt_acknowledge_n_i(ack_n), .interrupt_acknowledge_n_o(ack_o),
        .interrupt_acknowledge_n_oe(ack_oe), .request_level_n_o(level_o),
        .request_level_n_oe(level_oe), .group_inhibit_out(group_inhibit_out));
    piu_cpu_model piu_cpu_model_inst (.clock(clock), .strobe_on(strobe_on), .slow(slow),
        .ret(ret), .ack_n(ack_n), .level_n(level_n), .strobe_enable(strobe_enable),
        .level_read_en_n(level_read_en_n), .status_load_n(status_load_n),
        .current_level_n(current_level_n), .status_group_select_n(status_group_select_n),
        .served(served), .served_level(served_level));

    // ********
    // tasks
    // ********
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        num_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic test_done();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    function automatic logic [2:0] hi(input logic [7:0] b);
        hi = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                hi = 3'(i);
            end
        end
    endfunction : hi

    task automatic quiet();
        c0 = acks;
        repeat (8) @(negedge clock);
        check(8'(acks - c0), 8'h0);
    endtask : quiet

    // bounded wait until every noted level was serviced
    task automatic drain();
        for (int i = 0; i < 60 && exp_q.size() > 0; i++) @(negedge clock);
        check(8'(exp_q.size()), 8'h0);
        repeat (2) @(negedge clock);
    endtask : drain

    task automatic unwind();
        repeat (2) begin
            @(negedge clock) ret <= 1'b1;
            @(negedge clock) ret <= 1'b0;
            repeat (2) @(negedge clock);
        end
    endtask : unwind

    // ********
    // watcher
    // ********
    always @(posedge clock) begin
        cycles++;
        if (ack_oe === 1'b1) begin
            acks++;
        end
        if (served === 1'b1) begin
            if (exp_q.size() == 0) begin
                check({5'h0, served_level}, 8'hff);
            end else begin
                check({5'h0, served_level}, {5'h0, exp_q.pop_front()});
            end
        end
        if (cycles == 3000) begin
            num_errors++;
            test_done();
        end
    end

    initial begin
        void'($urandom(52549));
        repeat (6) @(posedge clock);
        @(negedge clock) resetn <= 1'b1;
        @(negedge clock) request_n <= 8'hf6;
        quiet();
        check({7'h0, group_inhibit_out}, 8'h0);
        @(negedge clock) group_inhibit_in <= 1'b1;
        // a frozen unit must not acknowledge although every condition holds
        clock_enable <= 1'b0;
        quiet();
        @(negedge clock) clock_enable <= 1'b1;
        exp_q.push_back(3'h3);
        drain();
        @(negedge clock) strobe_on <= 1'b0;
        request_n <= 8'hbf;
        quiet();
        check({7'h0, level_oe}, 8'h0);
        @(negedge clock) strobe_on <= 1'b1;
        exp_q.push_back(3'h6);
        drain();
        @(negedge clock) request_n <= 8'hbb;
        quiet();
        check({7'h0, level_oe}, 8'h0);
        @(negedge clock) request_n <= 8'hff;
        unwind();
        check({7'h0, group_inhibit_out}, 8'h1);
        repeat (16) begin
            @(negedge clock) bits = 8'($urandom_range(255, 1));
            h = hi(bits);
            c0 = acks;
            slow <= 2'($urandom);
            request_n <= ~bits;
            exp_q.push_back(h);
            for (int i = 0; i < 20 && ack_n !== 1'b0; i++) @(negedge clock);
            // a higher request during service must wait for the status load
            if (h < 3'h7) begin
                request_n <= 8'h7f;
                exp_q.push_back(3'h7);
            end
            drain();
            check(8'(acks - c0), (h < 3'h7) ? 8'h2 : 8'h1);
            @(negedge clock) request_n <= 8'hff;
            unwind();
        end
        test_done();
    end
endmodule : test_priority_interrupt_unit
